/* File: core/pwg_consts.vh */
/*
 holds the command codes, register reset values, protection levels and field positions
 of the write guard and setpoint register slice.
 assumes it is included by bare name from core design files only.
*/
// Summary of operation
// - the protection level resets to 00h, and at that level every command accepts writes.
// - at level 40h only protection level, run control, fault clear and page select accept writes.
// - at level 20h on/off configuration, setpoint and trim also accept writes, others are refused.
// - writing any protection value other than 00h, 20h or 40h raises an invalid data fault.
// - the voltage format code is one read-only shared byte that always reads 40h.
// - each output regulates to its own setpoint whenever its run control selects nominal.
// - the setpoint is an unsigned 16-bit millivolt value reset to 0384h, stored as written without bounds.
// - the trim is added as a fixed offset to the source chosen by run control to form the voltage target.
// - the trim is a signed 16-bit millivolt value reset to 0000h, stored as written without a range limit.
// - protection level and format code are shared, setpoint and trim are held per output.
// - per-output commands follow the page, 00h output 0, 01h output 1, FFh both outputs on writes and output 0 on reads.
// - run control source 00 selects the setpoint, 01 the low margin, 10 the high margin.
// - direct-format words are two-byte two's-complement integers.
`ifndef PWG_CONSTS_VH
`define PWG_CONSTS_VH

`define PWG_CMD_PAGE 8'h00
`define PWG_CMD_RUN_CTRL 8'h01
`define PWG_CMD_ONOFF_CFG 8'h02
`define PWG_CMD_CLEAR_FAULTS 8'h03
`define PWG_CMD_WRITE_LOCK 8'h10
`define PWG_CMD_FORMAT 8'h20
`define PWG_CMD_SETPOINT 8'h21
`define PWG_CMD_TRIM 8'h22

`define PWG_LOCK_NONE 8'h00
`define PWG_LOCK_PARTIAL 8'h20
`define PWG_LOCK_FULL 8'h40
`define PWG_FORMAT_VALUE 8'h40
`define PWG_SETPOINT_RESET 16'h0384
`define PWG_TRIM_RESET 16'h0000
`define PWG_TRIM_LIMIT 16'h00FA

`define PWG_PAGE_OUT0 8'h00
`define PWG_PAGE_OUT1 8'h01
`define PWG_PAGE_BOTH 8'hFF

`define PWG_SRC_NOMINAL 2'b00
`define PWG_SRC_LOW 2'b01
`define PWG_SRC_HIGH 2'b10
`define PWG_SRC_MSB 5
`define PWG_SRC_LSB 4

`endif

/* File: core/pwg_out_regs.v */
/*
 holds the setpoint and trim words of one output and forms its voltage target.
 assumes the parent decides acceptance and page selection; writes arrive as one-cycle strobes.
*/
`default_nettype none
`include "pwg_consts.vh"
module pwg_out_regs
#(
   parameter WIDTH = 16
)
(
   input wire core_clk_in,
   input wire nrst_in,
   input wire set_we_in,
   input wire trim_we_in,
   input wire [WIDTH-1:0] wdata_in,
   input wire [1:0] src_sel_in,
   input wire [WIDTH-1:0] low_margin_level_in,
   input wire [WIDTH-1:0] high_margin_level_in,
   output reg [WIDTH-1:0] output_setpoint_out,
   output reg [WIDTH-1:0] output_trim_offset_out,
   output reg [WIDTH-1:0] target_out
);
   reg [WIDTH-1:0] next_target;
   reg [WIDTH-1:0] base;

   // setpoint and trim storage, separate copy per output
   always @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         output_setpoint_out <= `PWG_SETPOINT_RESET;
         output_trim_offset_out <= `PWG_TRIM_RESET;
      end
      else
      begin
         if (set_we_in)
            output_setpoint_out <= wdata_in;
         if (trim_we_in)
            output_trim_offset_out <= wdata_in;
      end
   end

   // source choice then trim as fixed offset, wraps in 16 bits
   always @*
   begin
      case (src_sel_in)
         `PWG_SRC_NOMINAL: base = output_setpoint_out;
         `PWG_SRC_LOW: base = low_margin_level_in;
         `PWG_SRC_HIGH: base = high_margin_level_in;
         default: base = output_setpoint_out;
      endcase
      next_target = base + output_trim_offset_out;
   end

   // target registered so the data output comes from a flip-flop
   always @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         target_out <= `PWG_SETPOINT_RESET;
      else
         target_out <= next_target;
   end
endmodule
`default_nettype wire

/* File: core/pwg_write_guard.v */
/*
 holds the write guard and the shared registers of the setpoint slice, decodes command
 writes and reads, and instantiates one setpoint/trim bank per output.
 assumes a protocol front end delivers assembled command writes and reads as one-cycle
 strobes on core_clk_in, and that page, run control and margin levels live elsewhere.
*/
`default_nettype none
`include "pwg_consts.vh"
module pwg_write_guard
#(
   parameter WIDTH = 16
)
(
   input wire core_clk_in,
   input wire nrst_in,
   input wire wr_in,
   input wire rd_in,
   input wire [7:0] cmd_in,
   input wire [WIDTH-1:0] wdata_in,
   input wire [7:0] page_in,
   input wire [7:0] run_ctrl0_in,
   input wire [7:0] run_ctrl1_in,
   input wire [WIDTH-1:0] low_margin_level0_in,
   input wire [WIDTH-1:0] high_margin_level0_in,
   input wire [WIDTH-1:0] low_margin_level1_in,
   input wire [WIDTH-1:0] high_margin_level1_in,
   output wire wr_accept_out,
   output reg wr_refused_out,
   output reg invalid_data_out,
   output reg rd_valid_out,
   output reg [WIDTH-1:0] rdata_out,
   output wire [WIDTH-1:0] target0_out,
   output wire [WIDTH-1:0] target1_out
);
   reg [7:0] write_lock_level;
   wire [WIDTH-1:0] set0;
   wire [WIDTH-1:0] set1;
   wire [WIDTH-1:0] trim0;
   wire [WIDTH-1:0] trim1;
   wire lock_wr;
   wire lock_ok;
   wire [1:0] sel;
   wire [1:0] set_we;
   wire [1:0] trim_we;
   wire [WIDTH-1:0] lo [0:1];
   wire [WIDTH-1:0] hi [0:1];
   wire [1:0] src [0:1];
   wire [WIDTH-1:0] tgt [0:1];
   wire [WIDTH-1:0] setv [0:1];
   wire [WIDTH-1:0] trimv [0:1];

   // permission of one command under a protection level
   function allowed;
      input [7:0] level;
      input [7:0] cmd;
      reg base_ok;
      begin
         base_ok = (cmd == `PWG_CMD_WRITE_LOCK) || (cmd == `PWG_CMD_RUN_CTRL) ||
            (cmd == `PWG_CMD_CLEAR_FAULTS) || (cmd == `PWG_CMD_PAGE);
         case (level)
            `PWG_LOCK_NONE: allowed = 1'b1;
            `PWG_LOCK_FULL: allowed = base_ok;
            `PWG_LOCK_PARTIAL: allowed = base_ok || (cmd == `PWG_CMD_ONOFF_CFG) ||
               (cmd == `PWG_CMD_SETPOINT) || (cmd == `PWG_CMD_TRIM);
            default: allowed = 1'b1;
         endcase
      end
   endfunction

   // legal protection values
   function lock_legal;
      input [7:0] v;
      begin
         lock_legal = (v == `PWG_LOCK_NONE) || (v == `PWG_LOCK_PARTIAL) ||
            (v == `PWG_LOCK_FULL);
      end
   endfunction

   // acceptance and page decode
   assign wr_accept_out = wr_in && allowed(write_lock_level, cmd_in);
   assign lock_wr = wr_accept_out && (cmd_in == `PWG_CMD_WRITE_LOCK);
   assign lock_ok = lock_legal(wdata_in[7:0]);
   assign sel[0] = (page_in == `PWG_PAGE_OUT0) || (page_in == `PWG_PAGE_BOTH);
   assign sel[1] = (page_in == `PWG_PAGE_OUT1) || (page_in == `PWG_PAGE_BOTH);
   assign src[0] = run_ctrl0_in[`PWG_SRC_MSB:`PWG_SRC_LSB];
   assign src[1] = run_ctrl1_in[`PWG_SRC_MSB:`PWG_SRC_LSB];
   assign lo[0] = low_margin_level0_in;
   assign lo[1] = low_margin_level1_in;
   assign hi[0] = high_margin_level0_in;
   assign hi[1] = high_margin_level1_in;

   // one setpoint/trim bank per output
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_out
         assign set_we[gi] = wr_accept_out && sel[gi] && (cmd_in == `PWG_CMD_SETPOINT);
         assign trim_we[gi] = wr_accept_out && sel[gi] && (cmd_in == `PWG_CMD_TRIM);
         pwg_out_regs #(.WIDTH(WIDTH)) u_out
         (
            .core_clk_in(core_clk_in),
            .nrst_in(nrst_in),
            .set_we_in(set_we[gi]),
            .trim_we_in(trim_we[gi]),
            .wdata_in(wdata_in),
            .src_sel_in(src[gi]),
            .low_margin_level_in(lo[gi]),
            .high_margin_level_in(hi[gi]),
            .output_setpoint_out(setv[gi]),
            .output_trim_offset_out(trimv[gi]),
            .target_out(tgt[gi])
         );
      end
   endgenerate

   assign set0 = setv[0];
   assign set1 = setv[1];
   assign trim0 = trimv[0];
   assign trim1 = trimv[1];
   assign target0_out = tgt[0];
   assign target1_out = tgt[1];

   // shared protection level, illegal values kept out and flagged
   always @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         write_lock_level <= `PWG_LOCK_NONE;
         invalid_data_out <= 1'b0;
         wr_refused_out <= 1'b0;
      end
      else
      begin
         if (lock_wr && lock_ok)
            write_lock_level <= wdata_in[7:0];
         invalid_data_out <= lock_wr && !lock_ok;
         wr_refused_out <= wr_in && !wr_accept_out;
      end
   end

   // read mux; page FFh reads output 0; unmapped reads zero
   always @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         rd_valid_out <= 1'b0;
         rdata_out <= {WIDTH{1'b0}};
      end
      else
      begin
         rd_valid_out <= rd_in;
         if (rd_in)
         begin
            case (cmd_in)
               `PWG_CMD_WRITE_LOCK: rdata_out <= {{(WIDTH-8){1'b0}}, write_lock_level};
               `PWG_CMD_FORMAT: rdata_out <= {{(WIDTH-8){1'b0}}, `PWG_FORMAT_VALUE};
               `PWG_CMD_SETPOINT: rdata_out <= sel[0] ? set0 : set1;
               `PWG_CMD_TRIM: rdata_out <= sel[0] ? trim0 : trim1;
               default: rdata_out <= {WIDTH{1'b0}};
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* File: testbench/pwg_guard_props.sv */
/* port checker of the write guard slice
   assumes it is bound onto pwg_write_guard and sees its ports only */
`default_nettype none
module pwg_guard_props
#(
   parameter WIDTH = 16
)
(
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] cmd_in,
   input wire logic [WIDTH-1:0] wdata_in,
   input wire logic wr_accept_out,
   input wire logic wr_refused_out,
   input wire logic invalid_data_out,
   input wire logic rd_valid_out,
   input wire logic [WIDTH-1:0] rdata_out,
   input wire logic [WIDTH-1:0] target0_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   // shadow of the protection level, lock writes are never refused
   logic [7:0] lvl;
   always @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         lvl <= 8'h00;
      else if (wr_in && cmd_in == 8'h10 && wdata_in[7:0] inside {8'h00, 8'h20, 8'h40})
         lvl <= wdata_in[7:0];
   end
   // write to a command that the shadow level locks
   sequence s_locked_wr;
      wr_in && lvl != 8'h00 && !(cmd_in inside {8'h00, 8'h01, 8'h03, 8'h10}) &&
         !(lvl == 8'h20 && cmd_in inside {8'h02, 8'h21, 8'h22});
   endsequence
   // refusal seen as no accept now and a flag one cycle later
   sequence s_refused;
      !wr_accept_out ##1 wr_refused_out;
   endsequence
   // lock write carrying a value outside the three levels
   sequence s_bad_lock;
      wr_in && cmd_in == 8'h10 && !(wdata_in[7:0] inside {8'h00, 8'h20, 8'h40});
   endsequence
   // properties on the port relations
   property p_rdv; rd_in |=> rd_valid_out; endproperty
   property p_hold; !rd_in |=> $stable(rdata_out); endproperty
   property p_fmt; rd_in && cmd_in == 8'h20 |=> rdata_out == 16'h0040; endproperty
   property p_ok; wr_in && cmd_in inside {8'h00, 8'h01, 8'h03, 8'h10} |-> wr_accept_out; endproperty
   property p_ref; s_locked_wr |-> s_refused; endproperty
   property p_inv; s_bad_lock |=> invalid_data_out; endproperty
   property p_inv_cause; invalid_data_out |-> $past(wr_in) && $past(cmd_in) == 8'h10; endproperty
   property p_rst; $rose(nrst_in) |-> target0_out == 16'h0384; endproperty
   a_rdv: assert property (p_rdv) else $error("read answer missing");
   a_hold: assert property (p_hold) else $error("read data moved");
   a_fmt: assert property (p_fmt) else $error("format code wrong");
   a_ok: assert property (p_ok) else $error("free command blocked");
   a_ref: assert property (p_ref) else $error("refusal flag missing");
   a_inv: assert property (p_inv) else $error("bad level not flagged");
   a_inv_cause: assert property (p_inv_cause) else $error("stray fault");
   a_rst: assert property (p_rst) else $error("target reset wrong");
endmodule
bind pwg_write_guard pwg_guard_props #(.WIDTH(WIDTH)) props_u (.core_clk_in, .nrst_in, .wr_in,
   .rd_in, .cmd_in, .wdata_in, .wr_accept_out, .wr_refused_out, .invalid_data_out,
   .rd_valid_out, .rdata_out, .target0_out);
`default_nettype wire

/* File: testbench/pwg_host_model.sv */
/* bus host that issues one command write or read at a time
   assumes the bench calls xfer and supplies page and run control itself */
`default_nettype none
module pwg_host_model
(
   input wire logic core_clk_in,
   input wire logic [15:0] rdata_in,
   output logic wr_out,
   output logic rd_out,
   output logic [7:0] cmd_out,
   output logic [15:0] wdata_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus at time zero
   initial
   begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      cmd_out = 8'h00;
      wdata_out = 16'h0000;
   end
   // one strobe cycle with the whole word, after an idle gap
   task xfer(input logic rd, input logic [7:0] c, input logic [15:0] d, input int gap,
      output logic [15:0] q);
      repeat (gap) @(posedge core_clk_in);
      @(posedge core_clk_in);
      wr_out <= !rd;
      rd_out <= rd;
      cmd_out <= c;
      wdata_out <= d;
      @(posedge core_clk_in);
      wr_out <= 1'b0;
      rd_out <= 1'b0;
      wdata_out <= ~d; // no stale word left on the bus
      @(posedge core_clk_in);
      q = rdata_in; // read word taken at the edge where its valid flag is high
   endtask
endmodule
`default_nettype wire

/* File: testbench/tb_pwg_write_guard.sv */
/* self-checking bench of the write guard slice
   assumes the host model drives the strobes and this module the side inputs */
`default_nettype none
module tb_pwg_write_guard;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic wr, rd, wacc, wref, inv, rdv, bad;
   logic [7:0] cmd, c, pg, lock, page = 8'h00, rc0 = 8'h00, rc1 = 8'h00;
   logic [15:0] wd, wv, q, rdat, t0, t1, lo0 = 16'h00FA, hi0 = 16'h0640, lo1 = 16'h0100;
   logic [15:0] hi1 = 16'h0700;
   logic [15:0] sp [2];
   logic [15:0] tr [2];
   logic [7:0] cmds [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h20, 8'h21, 8'h22};
   logic [7:0] pgs [3] = '{8'h00, 8'h01, 8'hFF};
   logic [7:0] lvls [3] = '{8'h00, 8'h20, 8'h40};
   integer error_cnt = 0, samples_checked = 0, cyc = 0, seed = 32'h13B4, i, k;
   always #10 core_clk_in = ~core_clk_in;
   pwg_write_guard #(.WIDTH(16)) dut_u (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
      .wr_in(wr), .rd_in(rd), .cmd_in(cmd), .wdata_in(wd), .page_in(page), .run_ctrl0_in(rc0),
      .run_ctrl1_in(rc1), .low_margin_level0_in(lo0), .high_margin_level0_in(hi0),
      .low_margin_level1_in(lo1), .high_margin_level1_in(hi1), .wr_accept_out(wacc),
      .wr_refused_out(wref), .invalid_data_out(inv), .rd_valid_out(rdv), .rdata_out(rdat),
      .target0_out(t0), .target1_out(t1));
   pwg_host_model host_u (.core_clk_in(core_clk_in), .rdata_in(rdat), .wr_out(wr),
      .rd_out(rd), .cmd_out(cmd), .wdata_out(wd));
   // write permission per protection level
   function logic acc(input logic [7:0] l, input logic [7:0] x);
      return l == 8'h00 || x inside {8'h00, 8'h01, 8'h03, 8'h10} ||
         (l == 8'h20 && x inside {8'h02, 8'h21, 8'h22});
   endfunction
   // target from run control source plus trim
   function logic [15:0] tgt(input logic [7:0] r, input logic [15:0] lo, hi, s, t);
      return (r[5:4] == 2'b01 ? lo : r[5:4] == 2'b10 ? hi : s) + t;
   endfunction
   task chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %0t got %h expected %h", $time, g, e);
      end
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // cycle ceiling against a hang
   always @(posedge core_clk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         error_cnt++;
         summarize;
      end
   end
   initial
   begin
      repeat (8) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      lock = 8'h00;
      sp = '{16'h0384, 16'h0384};
      tr = '{16'h0000, 16'h0000};
      for (k = 0; k < 60; k++)
      begin
         if (k > 0)
         begin
            c = cmds[$unsigned($random(seed)) % 8];
            pg = pgs[$unsigned($random(seed)) % 3];
            wv = $random(seed);
            if (c == 8'h10 && wv[15:14] != 2'b11)
               wv = {8'h00, lvls[wv[1:0] % 3]};
            if (k == 1)
               {c, pg, wv} = {8'h22, 8'hFF, 16'hFF06};
            if (k == 2)
               {c, pg, wv} = {8'h10, 8'h00, 16'h0055};
            bad = c == 8'h10 && !(wv[7:0] inside {8'h00, 8'h20, 8'h40});
            page <= pg;
            rc0 <= $random(seed);
            rc1 <= $random(seed);
            lo0 <= $random(seed);
            hi1 <= $random(seed);
            host_u.xfer(1'b0, c, wv, k % 3, q);
            chk({15'h0000, wref}, {15'h0000, !acc(lock, c)});
            chk({15'h0000, inv}, {15'h0000, bad});
            if (c == 8'h10 && !bad)
               lock = wv[7:0];
            else if (acc(lock, c) && c inside {8'h21, 8'h22})
               for (i = 0; i < 2; i++)
                  if (pg == i || pg == 8'hFF)
                     if (c == 8'h21) sp[i] = wv;
                     else tr[i] = wv;
         end
         page <= 8'h00;
         host_u.xfer(1'b1, 8'h10, 16'h0000, 0, q);
         chk(q, {8'h00, lock});
         host_u.xfer(1'b1, 8'h20, 16'h0000, 0, q);
         chk(q, 16'h0040);
         chk({15'h0000, rdv}, 16'h0001);
         for (i = 0; i < 2; i++)
         begin
            page <= i;
            host_u.xfer(1'b1, 8'h21, 16'h0000, 0, q);
            chk(q, sp[i]);
            host_u.xfer(1'b1, 8'h22, 16'h0000, 0, q);
            chk(q, tr[i]);
         end
         chk(t0, tgt(rc0, lo0, hi0, sp[0], tr[0]));
         chk(t1, tgt(rc1, lo1, hi1, sp[1], tr[1]));
         $display("test %0d done", k);
      end
      summarize;
   end
endmodule
`default_nettype wire
